// ==== port_error_log.sv ====
// root port unit error detect mask and first/next error logs behind APB
//
// The APB register port is this design's own decision.
`include "port_error_log_defines.svh"
`default_nettype none
module port_error_log
  import port_error_log_pkg::*;
(
  // clock and resets
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic sys_reset_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  // unit error sources, bit positions follow the detect mask
  input wire logic [15:0] unit_src_i,
  // internally detected device errors
  input wire logic dev_fatal_i,
  input wire logic dev_nonfatal_i,
  input wire logic dev_cor_i,
  // error messages received from the link
  input wire logic msg_fatal_i,
  input wire logic msg_nonfatal_i,
  input wire logic msg_cor_i,
  // status
  output logic [15:0] unit_detected_o,
  output logic irq_o
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
    addr_is = (a[11:2] == off[11:2]);
  endfunction

  wire setup_phase;
  wire access_phase;
  wire wr_access;
  wire sel_detect;
  wire sel_first;
  wire sel_next;
  wire sel_ctrl;
  wire sel_irq_st;
  wire sel_irq_mask;
  wire addr_hit;
  wire full_word;

  assign setup_phase = psel_i & ~penable_i;
  assign access_phase = psel_i & penable_i;
  assign wr_access = access_phase & pwrite_i;
  assign sel_detect = addr_is(paddr_i, `OFF_DETECT_MASK);
  assign sel_first = addr_is(paddr_i, `OFF_FIRST_LOG);
  assign sel_next = addr_is(paddr_i, `OFF_NEXT_LOG);
  assign sel_ctrl = addr_is(paddr_i, `OFF_CONTROL);
  assign sel_irq_st = addr_is(paddr_i, `OFF_IRQ_STATUS);
  assign sel_irq_mask = addr_is(paddr_i, `OFF_IRQ_MASK);
  assign addr_hit = sel_detect | sel_first | sel_next | sel_ctrl | sel_irq_st | sel_irq_mask;
  // the low lanes hold every implemented bit; byte lanes 0 and 1 gate the write
  assign full_word = pstrb_i[0] & pstrb_i[1];

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  unit_vec_t detect_mask;
  log_vec_t first_log;
  log_vec_t next_log;
  logic serr_en;
  irq_vec_t irq_status;
  irq_vec_t irq_mask;
  logic [31:0] rdata;
  logic slverr;

  // ---------------------------------------------------------------
  // unit error classification
  // ---------------------------------------------------------------
  wire [15:0] unit_detected;
  wire [2:0] unit_sev;

  unit_error_classify u_classify (
    .unit_src_i(unit_src_i),
    .detect_mask_i(detect_mask),
    .unit_detected_o(unit_detected),
    .unit_sev_o(unit_sev)
  );

  // ---------------------------------------------------------------
  // event vector in log layout
  // ---------------------------------------------------------------
  wire [2:0] dev_events;
  wire [2:0] unit_events;
  wire [2:0] msg_events;
  wire [8:0] events;

  assign dev_events = {dev_fatal_i, dev_nonfatal_i, dev_cor_i}; // [R12]
  assign unit_events = {unit_sev[2], unit_sev[1], unit_sev[0]}; // [R13] [R14]
  // messages only count while serr enable is set [R16]
  assign msg_events = {msg_fatal_i, msg_nonfatal_i, msg_cor_i} & {3{serr_en}}; // [R15]
  assign events = {dev_events, unit_events, msg_events};

  // ---------------------------------------------------------------
  // software clears, write-one-to-clear
  // ---------------------------------------------------------------
  wire [8:0] clr_first;
  wire [8:0] clr_next;
  wire [1:0] clr_irq;

  assign clr_first = (wr_access & sel_first & full_word) ? pwdata_i[8:0] : 9'h000; // [R11]
  assign clr_next = (wr_access & sel_next & full_word) ? pwdata_i[8:0] : 9'h000; // [R11]
  assign clr_irq = (wr_access & sel_irq_st & pstrb_i[0]) ? pwdata_i[1:0] : 2'h0;

  // ---------------------------------------------------------------
  // per-category capture steering
  // ---------------------------------------------------------------
  wire [8:0] first_set;
  wire [8:0] next_set;
  wire [2:0] cat_locked;

  genvar g;
  generate
    for (g = 0; g < `CAT_GROUPS; g = g + 1) begin : g_cat
      // a category is locked while any of its first-log bits is held [R18]
      assign cat_locked[g] = |first_log[g*`CAT_BITS +: `CAT_BITS];
      // every event of an open category lands in the first log together [R9] [R10]
      assign first_set[g*`CAT_BITS +: `CAT_BITS] =
        cat_locked[g] ? 3'h0 : events[g*`CAT_BITS +: `CAT_BITS];
      // later events of a locked category go to the next log [R17]
      assign next_set[g*`CAT_BITS +: `CAT_BITS] =
        cat_locked[g] ? events[g*`CAT_BITS +: `CAT_BITS] : 3'h0;
    end
  endgenerate

  // ---------------------------------------------------------------
  // next values
  // ---------------------------------------------------------------
  wire [15:0] next_detect_mask;
  wire [8:0] next_first_log;
  wire [8:0] next_next_log;
  wire next_serr_en;
  wire [1:0] irq_events;
  wire [1:0] next_irq_status;
  wire [1:0] next_irq_mask;
  wire detect_we;
  wire ctrl_we;
  wire irq_mask_we;

  assign detect_we = wr_access & sel_detect & full_word;
  assign ctrl_we = wr_access & sel_ctrl & pstrb_i[0];
  assign irq_mask_we = wr_access & sel_irq_mask & pstrb_i[0];

  // reserved bits of the mask never store a one [R1] [R7]
  assign next_detect_mask = detect_we ? (pwdata_i[15:0] & `DETECT_MASK_RW) : detect_mask;

  // a set in the same cycle as a clear wins, so no error is lost
  assign next_first_log = (first_log & ~clr_first) | first_set; // [R11] [R18]
  assign next_next_log = (next_log & ~clr_next) | next_set; // [R11] [R17]

  assign next_serr_en = sys_reset_i ? `RST_CONTROL :
                        ctrl_we ? pwdata_i[`CTRL_SERR_EN_BIT] : serr_en;

  assign irq_events[`IRQ_FIRST_BIT] = |first_set;
  assign irq_events[`IRQ_NEXT_BIT] = |next_set;
  assign next_irq_status = sys_reset_i ? `RST_IRQ : ((irq_status & ~clr_irq) | irq_events);
  assign next_irq_mask = sys_reset_i ? `RST_IRQ : irq_mask_we ? pwdata_i[1:0] : irq_mask;

  // ---------------------------------------------------------------
  // sticky registers: of the two resets only the power-on reset clears them, the
  // system reset input leaves them alone so errors survive a reboot
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      detect_mask <= `RST_DETECT_MASK; // [R1]
      first_log <= `RST_LOG; // [R9]
      next_log <= `RST_LOG;
    end else begin
      detect_mask <= next_detect_mask;
      first_log <= next_first_log;
      next_log <= next_next_log;
    end
  end

  // non-sticky control and interrupt state
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      serr_en <= `RST_CONTROL;
      irq_status <= `RST_IRQ;
      irq_mask <= `RST_IRQ;
    end else begin
      serr_en <= next_serr_en;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
    end
  end

  // ---------------------------------------------------------------
  // read path: data is sampled in the setup phase so it is stable
  // from flip-flops through the zero-wait access phase
  // ---------------------------------------------------------------
  wire [31:0] read_word;
  wire [31:0] rd_detect;
  wire [31:0] rd_first;
  wire [31:0] rd_next;
  wire [31:0] rd_ctrl;
  wire [31:0] rd_irq_st;
  wire [31:0] rd_irq_mask;
  wire [31:0] next_rdata;
  wire next_slverr;

  assign rd_detect = {16'h0000, detect_mask}; // [R1]
  assign rd_first = {23'h000000, first_log}; // [R9]
  assign rd_next = {23'h000000, next_log};
  assign rd_ctrl = {31'h00000000, serr_en};
  assign rd_irq_st = {30'h00000000, irq_status};
  assign rd_irq_mask = {30'h00000000, irq_mask};

  assign read_word = ({32{sel_detect}} & rd_detect)
                   | ({32{sel_first}} & rd_first)
                   | ({32{sel_next}} & rd_next)
                   | ({32{sel_ctrl}} & rd_ctrl)
                   | ({32{sel_irq_st}} & rd_irq_st)
                   | ({32{sel_irq_mask}} & rd_irq_mask);

  assign next_rdata = (setup_phase & ~pwrite_i) ? read_word :
                      setup_phase ? 32'h00000000 : rdata;
  assign next_slverr = setup_phase ? ~addr_hit : slverr;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata <= 32'h00000000;
      slverr <= 1'b0;
    end else begin
      rdata <= next_rdata;
      slverr <= next_slverr;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // no wait states; an unmapped address answers with an error and
  // its write is dropped because no select matches
  assign pready_o = 1'b1;
  assign prdata_o = rdata;
  assign pslverr_o = slverr & access_phase;
  assign unit_detected_o = unit_detected;
  assign irq_o = |(irq_status & ~irq_mask);

endmodule // port_error_log
`default_nettype wire

// ==== port_error_log_defines.svh ====
// constants for the root port unit error detect mask and first/next error logs
// Operation
// R1: detect mask resets zero, sticky, 31:16 read zero
// R2: bits 15..13 mask upstream queue overflows
// R3: bit 12 masks link protocol logic errors
// R4: bit 11 masks link up-to-down transition error
// R5: bit 10 data queue, bit 9 table parity
// R6: bits 8..6 mask retry buffer parity errors
// R7: bit 5 masks packet timeout; 4:3 reserved
// R8: bits 2..0 mask management bus faults
// R9: first log captures first error per category
// R10: same-cycle errors all latch into first log
// R11: log bits clear only on written one
// R12: bits 8..6 device fatal, nonfatal, correctable
// R13: bits 5..3 unit fatal, nonfatal, correctable
// R14: report mask never blocks unit log bits
// R15: bits 2..0 received fatal, nonfatal, correctable messages
// R16: serr enable zero blocks received message bits
// R17: next log records errors after category locked
// R18: locked category reopens only after software clear
`ifndef PORT_ERROR_LOG_DEFINES_SVH
`define PORT_ERROR_LOG_DEFINES_SVH

// register byte offsets
`define OFF_DETECT_MASK 12'h158
`define OFF_FIRST_LOG 12'h160
`define OFF_NEXT_LOG 12'h164
`define OFF_CONTROL 12'h180
`define OFF_IRQ_STATUS 12'h184
`define OFF_IRQ_MASK 12'h188

// reset values
`define RST_DETECT_MASK 16'h0000
`define RST_LOG 9'h000
`define RST_CONTROL 1'h0
`define RST_IRQ 2'h0

// writable bits of the detect mask (31:16 and 4:3 reserved)
`define DETECT_MASK_RW 16'hFFE7

// severity of each unit error source, indexed by detect mask bit
`define UNIT_SEV_FATAL 16'hEFC0
`define UNIT_SEV_NONFATAL 16'h1020
`define UNIT_SEV_COR 16'h0007

// field positions
`define LOG_WIDTH 9
`define CTRL_SERR_EN_BIT 0
`define IRQ_FIRST_BIT 0
`define IRQ_NEXT_BIT 1
`define CAT_GROUPS 3
`define CAT_BITS 3

`endif

// ==== port_error_log_pkg.sv ====
// types shared by the port error log block
`default_nettype none
package port_error_log_pkg;
  typedef logic [31:0] word_t;
  typedef logic [15:0] unit_vec_t;
  typedef logic [8:0] log_vec_t;
  typedef logic [1:0] irq_vec_t;
  typedef enum logic [2:0] {
    SEV_COR = 3'b001,
    SEV_NONFATAL = 3'b010,
    SEV_FATAL = 3'b100
  } severity_t;
endpackage
`default_nettype wire

// ==== unit_error_classify.sv ====
// gates unit error sources by the detect mask and folds them into severities
`include "port_error_log_defines.svh"
`default_nettype none
module unit_error_classify
  import port_error_log_pkg::*;
(
  // raw sources, one per detect mask bit
  input wire logic [15:0] unit_src_i,
  input wire logic [15:0] detect_mask_i,
  // gated sources and severity summary
  output logic [15:0] unit_detected_o,
  output logic [2:0] unit_sev_o
);
  wire [15:0] gated;
  wire any_fatal;
  wire any_nonfatal;
  wire any_cor;

  // a set mask bit hides its source; reserved positions never detect
  assign gated = unit_src_i & ~detect_mask_i & `DETECT_MASK_RW; // [R2] [R3] [R4] [R5] [R6] [R7] [R8]
  assign any_fatal = |(gated & `UNIT_SEV_FATAL);
  assign any_nonfatal = |(gated & `UNIT_SEV_NONFATAL);
  assign any_cor = |(gated & `UNIT_SEV_COR);

  assign unit_detected_o = gated;
  // report mask is not consulted here, so logging is never blocked by it [R14]
  assign unit_sev_o = ({3{any_fatal}} & SEV_FATAL)
                    | ({3{any_nonfatal}} & SEV_NONFATAL)
                    | ({3{any_cor}} & SEV_COR);
endmodule // unit_error_classify
`default_nettype wire

// ==== port_error_log_monitor.sv ====
// assertion checker for the port error log register block
`default_nettype none
module port_error_log_monitor (
  // clock, resets and apb
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic sys_reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic pready_o,
  input wire logic [31:0] prdata_o,
  input wire logic pslverr_o,
  // unit error side
  input wire logic [15:0] unit_src_i,
  input wire logic [15:0] unit_detected_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  logic [15:0] wr_mask;
  wire access = psel_i && penable_i;
  wire rd_acc = access && !pwrite_i;
  // the design decodes whole words, so the byte lane bits do not matter
  wire [11:0] word_addr = {paddr_i[11:2], 2'b00};
  wire mapped = word_addr inside {12'h158, 12'h160, 12'h164, 12'h180, 12'h184, 12'h188};
  wire mask_wr = access && pwrite_i && paddr_i == 12'h158 && pstrb_i[1:0] == 2'h3;
  // write data of the previous cycle, sampled every clock, so a mask write can be followed into the gating
  always_ff @(posedge clock_i) begin
    wr_mask <= pwdata_i[15:0];
  end
  a_ready_always: assert property (psel_i |-> pready_o)
    else $error("pready low during a transfer");
  a_unmapped_err: assert property (access && !mapped |-> pslverr_o)
    else $error("unmapped access without error");
  a_unmapped_zero: assert property (rd_acc && !mapped |-> prdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_mapped_ok: assert property ((access && mapped) || (psel_i && !penable_i) |-> !pslverr_o)
    else $error("error flagged on a good access");
  a_mask_reserved: assert property (rd_acc && paddr_i == 12'h158 |->
    prdata_o[31:16] == 16'h0 && prdata_o[4:3] == 2'h0)
    else $error("reserved mask bits read nonzero");
  a_log_reserved: assert property (rd_acc && paddr_i inside {12'h160, 12'h164} |->
    prdata_o[31:9] == 23'h0)
    else $error("reserved log bits read nonzero");
  a_detect_gate: assert property ((unit_detected_o & ~unit_src_i) == 16'h0
    && unit_detected_o[4:3] == 2'h0)
    else $error("detection without a source");
  a_mask_applies: assert property (mask_wr |=>
    unit_detected_o == (unit_src_i & ~wr_mask & 16'hFFE7))
    else $error("written mask not applied");
  a_rdata_hold: assert property (access ##1 !psel_i && !sys_reset_i |-> $stable(prdata_o))
    else $error("read data moved while idle");
endmodule // port_error_log_monitor

bind port_error_log port_error_log_monitor port_error_log_monitor_inst (.clock_i(clock_i),
  .rst_b_i(rst_b_i), .sys_reset_i(sys_reset_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
  .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
  .unit_src_i(unit_src_i), .unit_detected_o(unit_detected_o));
`default_nettype wire

// ==== port_error_log_bench.sv ====
// self-checking bench for the port error log register block
`default_nettype none
module port_error_log_bench import port_error_log_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0, rst_b_i = 1'b0, sys_reset_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq, sl;
  logic [2:0] dev = 3'h0, msg = 3'h0;
  logic [11:0] paddr = 12'h0;
  logic [3:0] pstrb = 4'hF;
  logic [15:0] src = 16'h0, det, r;
  word_t pwdata = 32'h0, prdata, q, m;
  int mismatches = 0, n_compared = 0, cyc = 0;
  port_error_log port_error_log_inst (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .sys_reset_i(sys_reset_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr), .unit_src_i(src), .dev_fatal_i(dev[2]),
    .dev_nonfatal_i(dev[1]), .dev_cor_i(dev[0]), .msg_fatal_i(msg[2]),
    .msg_nonfatal_i(msg[1]), .msg_cor_i(msg[0]), .unit_detected_o(det), .irq_o(irq));
  initial forever #2.5 clock_i = ~clock_i;
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // a hang anywhere ends the run as a failure
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic chk(input word_t got, input word_t exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input word_t d);
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do @(posedge clock_i); while (pready !== 1'b1);
    q = prdata;
    sl = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input word_t d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input word_t e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // outputs settle just after the edge that updates registers
  task automatic irq_is(input logic e);
    #1;
    chk({31'h0, irq}, {31'h0, e});
  endtask
  task automatic ev(input logic [2:0] d, input logic [2:0] g, input logic [15:0] u);
    @(posedge clock_i);
    dev <= d;
    msg <= g;
    src <= u;
    @(posedge clock_i);
    dev <= 3'h0;
    msg <= 3'h0;
    src <= 16'h0;
  endtask
  function automatic word_t ubits(input logic [15:0] s);
    return {23'h0, 3'h0, |(s & 16'hEFC0), |(s & 16'h1020), |(s & 16'h0007), 3'h0};
  endfunction
  task automatic clr_logs();
    wr(12'h160, 32'h1FF);
    wr(12'h164, 32'h1FF);
    wr(12'h184, 32'h3);
  endtask
  initial begin
    void'($urandom(32'h0BAC));
    repeat (20) @(posedge clock_i);
    rst_b_i <= 1'b1;
    rd(12'h158, 32'h0);
    rd(12'h160, 32'h0);
    rd(12'h164, 32'h0);
    rd(12'h15C, 32'h0);
    chk({31'h0, sl}, 32'h1);
    $display("test reset values done");
    m = $urandom;
    wr(12'h158, m);
    rd(12'h158, m & 32'h0000FFE7);
    pstrb <= 4'h1;
    wr(12'h158, ~m);
    pstrb <= 4'hF;
    rd(12'h158, m & 32'h0000FFE7);
    src <= 16'hFFFF;
    for (int i = 0; i < 16; i++) begin
      wr(12'h158, 32'h1 << i);
      irq_is(1'b1);
      chk({16'h0, det}, {16'h0, 16'hFFE7 & ~(16'h1 << i)});
    end
    src <= 16'h0;
    wr(12'h158, 32'h0);
    clr_logs();
    irq_is(1'b0);
    $display("test detect mask done");
    ev(3'b101, 3'h0, 16'h0);
    rd(12'h160, 32'h140);
    irq_is(1'b1);
    ev(3'b010, 3'h0, 16'h0);
    rd(12'h164, 32'h080);
    wr(12'h160, 32'h0);
    rd(12'h160, 32'h140);
    wr(12'h160, 32'h100);
    rd(12'h160, 32'h040);
    ev(3'b100, 3'h0, 16'h0);
    rd(12'h164, 32'h180);
    wr(12'h160, 32'h040);
    ev(3'b010, 3'h0, 16'h0);
    rd(12'h160, 32'h080);
    wr(12'h188, 32'h3);
    irq_is(1'b0);
    wr(12'h188, 32'h0);
    irq_is(1'b1);
    clr_logs();
    irq_is(1'b0);
    rd(12'h164, 32'h0);
    $display("test first and next logs done");
    for (int k = 0; k < 8; k++) begin
      r = (k == 0) ? 16'h0018 : 16'($urandom);
      ev(3'h0, 3'h0, r);
      rd(12'h160, ubits(r));
      clr_logs();
    end
    $display("test unit errors done");
    ev(3'h0, 3'b111, 16'h0);
    rd(12'h160, 32'h0);
    wr(12'h180, 32'h1);
    for (int i = 0; i < 3; i++) begin
      ev(3'h0, 3'h1 << i, 16'h0);
      rd(12'h160, 32'h1 << i);
      clr_logs();
    end
    $display("test messages done");
    wr(12'h158, m);
    ev(3'b001, 3'h0, 16'h0);
    @(posedge clock_i);
    sys_reset_i <= 1'b1;
    @(posedge clock_i);
    sys_reset_i <= 1'b0;
    irq_is(1'b0);
    rd(12'h158, m & 32'h0000FFE7);
    rd(12'h160, 32'h040);
    rd(12'h180, 32'h0);
    $display("test system reset done");
    test_done();
  end
endmodule // port_error_log_bench
`default_nettype wire
